// ### hw/irq_chan_map.vh
// Register offsets, field positions and reset values of the interrupt channel
`ifndef IRQ_CHAN_MAP_VH
`define IRQ_CHAN_MAP_VH

// Register word indices (paddr[7:2])
`define OFS_VME_EN      6'h00
`define OFS_VME_STAT    6'h01
`define OFS_PCI_EN      6'h02
`define OFS_PCI_STAT    6'h03
`define OFS_PCI_MAP0    6'h04
`define OFS_PCI_MAP1    6'h05
`define OFS_VME_MAP1    6'h06
`define OFS_ERR_ATTR    6'h07
`define OFS_ERR_ADDR    6'h08
`define OFS_SID_BASE    6'h09
`define OFS_STATID1     6'h0A
`define OFS_STATID7     6'h10

// vme_irq_enable_reg fields
`define VEN_LVL_LO      1
`define VEN_SINGLE      8
`define VEN_VME_ERROR_STATUS_BIT        9
// vme_irq_status fields
`define VST_LVL_LO      1
`define VST_SINGLE      8
`define VST_VME_ERROR_STATUS_BIT        9
`define VST_SOFT_LO     17
// pci_irq_enable_reg and pci_irq_status fields
`define PEN_SOFT        0
`define PEN_ACKDONE     1
`define PEN_VME_ERROR_STATUS_BIT        2
`define PEN_LEVEL       3
// Map fields
`define MAP1_SOFT_LO    0
`define MAP1_ACK_LO     4
`define MAP1_VME_ERROR_STATUS_BIT_LO    8
`define VMAP1_SOFT_LO   0
`define VMAP1_VME_ERROR_STATUS_BIT_LO   4
// Attribute log fields
`define ATTR_AM_LO      0
`define ATTR_ERROR_FLAG_A       6
`define ATTR_WRITE      7
// Level status/ID register fields
`define SID_ERR         8

// Reset values
`define RST_MAP0        21'h000000
`define RST_MAP1        11'h000
`define RST_VMAP1       7'h00
`define RST_SID_BASE    7'h00

`endif

// ### hw/irq_line_fanout.v
// Steers a set of interrupt sources onto eight lines by 3-bit selectors
`timescale 1ns/1ps
`default_nettype none

module irq_line_fanout #(
	parameter N = 2
) (
	input  wire [N-1:0]   act,   // Source active levels
	input  wire [3*N-1:0] sel,   // Line selector per source
	output wire [7:0]     lines  // OR of all sources per line
);

	// One match vector per output line
	genvar j, i;
	generate
		for (j = 0; j < 8; j = j + 1) begin : gLine
			localparam integer LNUM = j;
			wire [N-1:0] match;
			for (i = 0; i < N; i = i + 1) begin : gSrc
				assign match[i] = act[i] & (sel[3*i +: 3] == LNUM[2:0]);
			end
			assign lines[j] = |match;
		end
	endgenerate

endmodule

`default_nettype wire

// ### hw/vme_pci_irq_channel.v
// Interrupt channel: bus-error logging, routing and software interrupts
`timescale 1ns/1ps
`default_nettype none
`include "irq_chan_map.vh"

// Function
// - Bus error logs failing address and command
// - Error during acknowledge sets error_flag_a
// - Bus error raises routable internal interrupt
// - Fetch error flags status/ID, still translates
// - Fetch error sets level status; only a bus error sets error status
// - Each source routes only to allowed buses
// - Per-level trigger bit asserts that level
// - Single trigger raises one mapped interrupt
// - Single trigger wins on shared level
// - Trigger acts only when bit was zero
// - Soft acknowledge raises enabled PCI interrupt
// - PCI trigger rising edge raises PCI interrupt
// - Map field selects PCI software line
// - Software fields trigger, never enable others
// - VME soft interrupts release on acknowledge
// - Soft acknowledge returns status/ID bit0 clear
module vme_pci_irq_channel (
	input  wire        clk,
	input  wire        rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Bus error report from the master interface
	input  wire        errPulse,
	input  wire [31:0] errAddr,
	input  wire [5:0]  errAm,
	input  wire        errWrite,
	input  wire        errIack,
	// Handler side: acknowledge cycle we ran has finished
	input  wire        ackDone,
	input  wire [2:0]  ackLevel,
	input  wire [7:0]  ackStatId,
	input  wire        ackErr,
	// Interrupter side: a handler acknowledges our request
	input  wire        iackIn,
	input  wire [2:0]  iackLevel,
	output reg  [7:0]  statIdOut,
	output reg         statIdValid,
	// Interrupt outputs
	output reg  [7:1]  vme_irq_out_level,
	output reg  [7:0]  pci_local_irq_pin
);

	// Bus handshake state
	reg  [31:0] rdMux;         // Read word chosen by index
	wire       wrEn;           // Write takes effect
	wire [5:0] idx;            // Word index
	assign wrEn = psel & penable & pwrite & pready;
	assign idx  = paddr[7:2];

	// Write strobes per register
	wire wVen   = wrEn & (idx == `OFS_VME_EN);
	wire wVst   = wrEn & (idx == `OFS_VME_STAT);
	wire wPen   = wrEn & (idx == `OFS_PCI_EN);
	wire wPst   = wrEn & (idx == `OFS_PCI_STAT);
	wire wMap0  = wrEn & (idx == `OFS_PCI_MAP0);
	wire wMap1  = wrEn & (idx == `OFS_PCI_MAP1);
	wire wVmap1 = wrEn & (idx == `OFS_VME_MAP1);
	wire wSid   = wrEn & (idx == `OFS_SID_BASE);

	// Software-written control
	reg  [7:1]  lvlTrigQ;      // level_soft_trigger_bits
	reg         singleTrigQ;   // single_soft_trigger toward VMEbus
	reg         vVerrEnQ;      // Bus error routed to VMEbus
	reg         pSoftTrigQ;    // single_soft_trigger toward PCI
	reg         pAckEnQ;       // soft_ack_done_enable
	reg         pVerrEnQ;      // Bus error routed to PCI
	reg         pLvlEnQ;       // Translated levels routed to PCI
	reg  [20:0] map0Q;         // pci_line_map0, 3 bits per level
	reg  [10:0] map1Q;         // pci_line_map1
	reg  [6:0]  vmap1Q;        // vme_level_map1
	reg  [7:1]  sidBaseQ;      // Our status/ID upper bits

	// Hardware-set state
	reg  [7:1]  lvlActQ;       // Per-level soft source active
	reg         singleActQ;    // Single soft source active
	reg         pSoftActQ;     // PCI soft source active
	reg  [7:1]  lvlStatQ;      // vme_level_status_bit
	reg         verrStatQ;     // vme_error_status_bit
	reg         ackDoneStatQ;  // Soft acknowledge complete
	reg  [31:0] logAddrQ;      // Failing address
	reg  [5:0]  logAmQ;        // Failing address modifier
	reg         logWrQ;        // Failing direction
	reg         logIackQ;      // error_flag_a
	reg  [8:0]  statIdQ [1:7]; // level_statusid_reg array

	// Trigger edges: a one written onto a zero only
	wire [7:1] lvlSet    = {7{wVen}} & pwdata[7:1] & ~lvlTrigQ;
	wire       singleSet = wVen & pwdata[`VEN_SINGLE] & ~singleTrigQ;
	wire       pSoftSet  = wPen & pwdata[`PEN_SOFT] & ~pSoftTrigQ;

	// Acknowledge of our own request, one-hot level
	wire [7:0] iackHot    = 8'h01 << iackLevel;
	wire       singleHere = singleActQ & (vmap1Q[2:0] == iackLevel);
	wire       lvlHere    = |(lvlActQ & iackHot[7:1]);
	wire       softHit    = iackIn & (singleHere | lvlHere);
	// Single source wins, so the per-level source waits for a later cycle
	wire       clrSingle  = iackIn & singleHere;
	wire [7:1] clrLvl     = {7{iackIn & ~singleHere}} & iackHot[7:1];

	// Handler completion, one-hot level
	wire [7:0] doneHot = ackDone ? (8'h01 << ackLevel) : 8'h00;

	// Handshake and read-back
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel & ~penable) begin
			// Setup cycle: answer in the first access cycle
			// No wait states: the read word is captured during setup
			pready  <= 1'b1;
			pslverr <= (idx > `OFS_STATID7);
			prdata  <= pwrite ? 32'h00000000 : rdMux;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Read multiplexer; unmapped words read zero
	always @* begin
		rdMux = 32'h00000000;
		case (idx)
			`OFS_VME_EN: begin
				rdMux[7:1]          = lvlTrigQ;
				rdMux[`VEN_SINGLE]  = singleTrigQ;
				rdMux[`VEN_VME_ERROR_STATUS_BIT]    = vVerrEnQ;
			end
			`OFS_VME_STAT: begin
				rdMux[7:1]                       = lvlStatQ;
				rdMux[`VST_SINGLE]               = singleActQ;
				rdMux[`VST_VME_ERROR_STATUS_BIT]                 = verrStatQ;
				rdMux[`VST_SOFT_LO+6:`VST_SOFT_LO] = lvlActQ;
			end
			`OFS_PCI_EN: begin
				rdMux[`PEN_SOFT]    = pSoftTrigQ;
				rdMux[`PEN_ACKDONE] = pAckEnQ;
				rdMux[`PEN_VME_ERROR_STATUS_BIT]    = pVerrEnQ;
				rdMux[`PEN_LEVEL]   = pLvlEnQ;
			end
			`OFS_PCI_STAT: begin
				// Active sources, routed or not; soft-ack done is set only while enabled
				rdMux[`PEN_SOFT]    = pSoftActQ;
				rdMux[`PEN_ACKDONE] = ackDoneStatQ;
				rdMux[`PEN_VME_ERROR_STATUS_BIT]    = verrStatQ;
				rdMux[`PEN_LEVEL]   = |lvlStatQ;
			end
			`OFS_PCI_MAP0: rdMux[20:0] = map0Q;
			`OFS_PCI_MAP1: rdMux[10:0] = map1Q;
			`OFS_VME_MAP1: rdMux[6:0]  = vmap1Q;
			`OFS_ERR_ATTR: begin
				rdMux[`ATTR_AM_LO+5:`ATTR_AM_LO] = logAmQ;
				rdMux[`ATTR_ERROR_FLAG_A]                = logIackQ;
				rdMux[`ATTR_WRITE]               = logWrQ;
			end
			`OFS_ERR_ADDR: rdMux = logAddrQ;
			`OFS_SID_BASE: rdMux[7:1] = sidBaseQ;
			default: begin
				// Level status/ID words
				if (idx >= `OFS_STATID1 && idx <= `OFS_STATID7)
					rdMux[8:0] = statIdQ[idx - `OFS_STATID1 + 6'h01];
			end
		endcase
	end

	// Control registers written by software
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lvlTrigQ    <= 7'h00;
			singleTrigQ <= 1'b0;
			vVerrEnQ    <= 1'b0;
			pSoftTrigQ  <= 1'b0;
			pAckEnQ     <= 1'b0;
			pVerrEnQ    <= 1'b0;
			pLvlEnQ     <= 1'b0;
			map0Q       <= `RST_MAP0;
			map1Q       <= `RST_MAP1;
			vmap1Q      <= `RST_VMAP1;
			sidBaseQ    <= `RST_SID_BASE;
		end else begin
			// Software fields hold trigger bits, not source enables
			if (wVen) begin
				lvlTrigQ    <= pwdata[7:1];
				singleTrigQ <= pwdata[`VEN_SINGLE];
				vVerrEnQ    <= pwdata[`VEN_VME_ERROR_STATUS_BIT];
			end
			if (wPen) begin
				pSoftTrigQ <= pwdata[`PEN_SOFT];
				pAckEnQ    <= pwdata[`PEN_ACKDONE];
				pVerrEnQ   <= pwdata[`PEN_VME_ERROR_STATUS_BIT];
				pLvlEnQ    <= pwdata[`PEN_LEVEL];
			end
			if (wMap0)
				map0Q <= pwdata[20:0];
			if (wMap1)
				map1Q <= pwdata[10:0];
			if (wVmap1)
				vmap1Q <= pwdata[6:0];
			if (wSid)
				sidBaseQ <= pwdata[7:1];
		end
	end

	// Soft sources: set on trigger edge, released by acknowledge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lvlActQ    <= 7'h00;
			singleActQ <= 1'b0;
		end else begin
			// Clearing the trigger bit also withdraws the source
			lvlActQ    <= lvlSet | (lvlActQ & ~clrLvl
				& ~({7{wVen}} & ~pwdata[7:1]));
			singleActQ <= singleSet | (singleActQ & ~clrSingle
				& ~(wVen & ~pwdata[`VEN_SINGLE]));
		end
	end

	// PCI soft source: raised by a fresh trigger edge, dropped when cleared
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pSoftActQ <= 1'b0;
		end else begin
			pSoftActQ <= pSoftSet
				| (pSoftActQ & ~(wPen & ~pwdata[`PEN_SOFT]));
		end
	end

	// Sticky status: hardware set wins over a written one
	// A written zero leaves every sticky bit as it is
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lvlStatQ     <= 7'h00;
			verrStatQ    <= 1'b0;
			ackDoneStatQ <= 1'b0;
		end else begin
			lvlStatQ  <= doneHot[7:1]
				| (lvlStatQ & ~({7{wVst}} & pwdata[7:1]));
			verrStatQ <= errPulse
				| (verrStatQ & ~(wVst & pwdata[`VST_VME_ERROR_STATUS_BIT]));
			ackDoneStatQ <= (softHit & pAckEnQ)
				| (ackDoneStatQ & ~(wPst & pwdata[`PEN_ACKDONE]));
		end
	end

	// Master error log, overwritten by every bus error
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			logAddrQ <= 32'h00000000;
			logAmQ   <= 6'h00;
			logWrQ   <= 1'b0;
			logIackQ <= 1'b0;
		end else if (errPulse) begin
			logAddrQ <= errAddr;
			logAmQ   <= errAm;
			logWrQ   <= errWrite;
			logIackQ <= errIack;
		end
	end

	// Level status/ID store, one word per level
	genvar g;
	generate
		for (g = 1; g <= 7; g = g + 1) begin : gSid
			always @(posedge clk or posedge rst) begin
				if (rst)
					statIdQ[g] <= 9'h000;
				else if (doneHot[g])
					statIdQ[g] <= {ackErr, ackStatId};
			end
		end
	endgenerate

	// Answer to a handler acknowledging our request
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			statIdOut   <= 8'h00;
			statIdValid <= 1'b0;
		end else begin
			statIdValid <= iackIn;
			if (iackIn)
				statIdOut <= {sidBaseQ, ~(singleHere | lvlHere)};
		end
	end

	// PCI routing: translated levels, soft, soft-ack done, bus error
	wire [9:0]  pciAct;
	wire [29:0] pciSel;
	wire [7:0]  pciLines;
	assign pciAct = {verrStatQ & pVerrEnQ, ackDoneStatQ, pSoftActQ,
		lvlStatQ & {7{pLvlEnQ}}};
	assign pciSel = {map1Q[`MAP1_VME_ERROR_STATUS_BIT_LO+2:`MAP1_VME_ERROR_STATUS_BIT_LO],
		map1Q[`MAP1_ACK_LO+2:`MAP1_ACK_LO],
		map1Q[`MAP1_SOFT_LO+2:`MAP1_SOFT_LO], map0Q};

	irq_line_fanout #(
		.N     (10)
	) uPci (
		.act   (pciAct),
		.sel   (pciSel),
		.lines (pciLines)
	);

	// VME routing: only the single soft source and bus error may be mapped
	// here; PCI-only sources have no path to these lines by construction
	// Fanout line 0 means not routed, so it is left unread
	wire [7:0] vmeLines;
	irq_line_fanout #(
		.N     (2)
	) uVme (
		.act   ({verrStatQ & vVerrEnQ, singleActQ}),
		.sel   ({vmap1Q[`VMAP1_VME_ERROR_STATUS_BIT_LO+2:`VMAP1_VME_ERROR_STATUS_BIT_LO],
			vmap1Q[`VMAP1_SOFT_LO+2:`VMAP1_SOFT_LO]}),
		.lines (vmeLines)
	);

	// Registered interrupt outputs; line 0 of the VME map selects no level
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			vme_irq_out_level <= 7'h00;
			pci_local_irq_pin <= 8'h00;
		end else begin
			vme_irq_out_level <= lvlActQ | vmeLines[7:1];
			pci_local_irq_pin <= pciLines;
		end
	end

endmodule

`default_nettype wire

// ### sim/irq_channel_chk.sv
// Port assertions for the interrupt channel
`timescale 1ns/1ps
`default_nettype none
module irq_channel_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        iackIn,
	input wire logic        statIdValid,
	input wire logic [7:1]  vme_irq_out_level,
	input wire logic [7:0]  pci_local_irq_pin
);
	logic       wrEn;       // Completed write
	logic [7:1] trigLvl_q;  // Level triggers as written
	logic       pciSoft_q;  // PCI trigger as written
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	assign wrEn = psel && penable && pready && pwrite;
	// Mirror triggers so only fresh 0-to-1 writes are judged
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trigLvl_q <= 7'h00;
			pciSoft_q <= 1'b0;
		end else if (wrEn && paddr == 8'h00) begin
			trigLvl_q <= pwdata[7:1];
		end else if (wrEn && paddr == 8'h08) begin
			pciSoft_q <= pwdata[0];
		end
	end
	chk_ready_phase: assert property (psel && !penable |=> pready)
		else $error("no ready");
	chk_ready_only: assert property (pready |-> psel && penable)
		else $error("stray ready");
	chk_slverr_range: assert property (pready && paddr[7:2] > 6'h10 |-> pslverr)
		else $error("no slave error");
	chk_slverr_ok: assert property (pready && paddr[7:2] <= 6'h10 |-> !pslverr)
		else $error("bad slave error");
	chk_statid_pulse: assert property (iackIn |=> statIdValid)
		else $error("no status answer");
	chk_valid_cause: assert property (statIdValid |-> $past(iackIn))
		else $error("stray status answer");
	chk_out_reset: assert property ($fell(rst) |-> !vme_irq_out_level && !pci_local_irq_pin)
		else $error("outputs after reset");
	chk_level_trig: assert property (wrEn && paddr == 8'h00 && pwdata[7:1] == 7'h7F
		&& trigLvl_q == 7'h00 |-> ##[1:3] vme_irq_out_level == 7'h7F)
		else $error("levels not raised");
	chk_pci_soft: assert property (wrEn && paddr == 8'h08 && pwdata[0] && !pciSoft_q
		|-> ##[1:3] pci_local_irq_pin != 8'h00)
		else $error("PCI soft not raised");
endmodule
bind vme_pci_irq_channel irq_channel_chk chk (.clk, .rst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .iackIn, .statIdValid, .vme_irq_out_level, .pci_local_irq_pin);
`default_nettype wire

// ### sim/vme_far_end.sv
// Behavioural VMEbus far side: errors, handler results, acknowledges
`timescale 1ns/1ps
`default_nettype none
module vme_far_end (
	input  wire logic  clk,
	output logic       errPulse,
	output logic [31:0] errAddr,
	output logic [5:0] errAm,
	output logic       errWrite,
	output logic       errIack,
	output logic       ackDone,
	output logic [2:0] ackLevel,
	output logic [7:0] ackStatId,
	output logic       ackErr,
	output logic       iackIn,
	output logic [2:0] iackLevel
);
	// All idle at time zero
	initial begin
		{errPulse, errAddr, errAm, errWrite, errIack, ackDone} = '0;
		{ackLevel, ackStatId, ackErr, iackIn, iackLevel} = '0;
	end
	// Bus error report; stale qualifiers are inverted, not held
	task busErr(input logic [39:0] q);
		@(posedge clk);
		errPulse <= 1'b1;
		{errAddr, errAm, errWrite, errIack} <= q;
		@(posedge clk);
		errPulse <= 1'b0;
		{errAddr, errAm, errWrite, errIack} <= ~q;
	endtask
	// Our handler cycle finished: level, status/ID, fetch error
	task done(input logic [11:0] q);
		@(posedge clk);
		ackDone <= 1'b1;
		{ackLevel, ackStatId, ackErr} <= q;
		@(posedge clk);
		ackDone <= 1'b0;
		{ackLevel, ackStatId, ackErr} <= ~q;
	endtask
	// A handler acknowledges our request on one level
	task ack(input logic [2:0] l);
		@(posedge clk);
		iackIn <= 1'b1;
		iackLevel <= l;
		@(posedge clk);
		iackIn <= 1'b0;
		iackLevel <= ~l;
	endtask
endmodule
`default_nettype wire

// ### sim/vme_pci_irq_channel_soft_err_test.sv
// Self-checking bench for the interrupt channel
`timescale 1ns/1ps
`default_nettype none
module vme_pci_irq_channel_soft_err_test;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, statIdOut, pci_local_irq_pin, ackStatId;
	logic [31:0] pwdata, prdata, rd, errAddr;
	logic [5:0]  errAm;
	logic [2:0]  ackLevel, iackLevel;
	logic        errPulse, errWrite, errIack, ackDone, ackErr, iackIn, statIdValid;
	logic [7:1]  vme_irq_out_level;
	int          miscompares, checks;
	vme_pci_irq_channel dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .errPulse, .errAddr, .errAm, .errWrite, .errIack, .ackDone,
		.ackLevel, .ackStatId, .ackErr, .iackIn, .iackLevel, .statIdOut, .statIdValid,
		.vme_irq_out_level, .pci_local_irq_pin);
	vme_far_end far (.clk, .errPulse, .errAddr, .errAm, .errWrite, .errIack, .ackDone,
		.ackLevel, .ackStatId, .ackErr, .iackIn, .iackLevel);
	// Free-running 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, request held until pready is sampled
	task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [5:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
	endtask
	task rdc(input logic [5:0] i, input logic [31:0] e);
		apb(1'b0, i, 32'h0);
		chk(rd, e);
	endtask
	// Let registered outputs settle
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Reset values, unmapped index, status/ID base
	task testRegs();
		for (int i = 0; i <= 16; i++) rdc(i[5:0], 32'h0);
		apb(1'b0, 6'h11, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b1);
		wr(6'h09, 32'hA5);
		rdc(6'h09, 32'hA4);
	endtask
	// Per-level triggers, acknowledge release, re-trigger
	task testLevels();
		wr(6'h00, 32'hFE);
		tick(2);
		chk(vme_irq_out_level, 7'h7F);
		rdc(6'h01, 32'h00FE0000);
		far.ack(3'd3);
		tick(0);
		chk(statIdOut, 8'hA4);
		tick(2);
		chk(vme_irq_out_level, 7'h7B);
		wr(6'h00, 32'hFE);
		tick(2);
		chk(vme_irq_out_level, 7'h7B);
		wr(6'h00, 32'h0);
		wr(6'h00, 32'h8);
		tick(2);
		chk(vme_irq_out_level, 7'h04);
		wr(6'h00, 32'h0);
	endtask
	// Single trigger shares level 3; ack-done to PCI line 1
	task testSingle();
		wr(6'h06, 32'h3);
		wr(6'h05, 32'h10);
		wr(6'h02, 32'h2);
		wr(6'h00, 32'h108);
		rdc(6'h01, 32'h00080100);
		far.ack(3'd3);
		tick(2);
		chk(vme_irq_out_level, 7'h04);
		rdc(6'h01, 32'h00080000);
		chk(pci_local_irq_pin, 8'h02);
		rdc(6'h03, 32'h2);
		far.ack(3'd3);
		tick(2);
		chk(vme_irq_out_level, 7'h00);
		wr(6'h00, 32'h0);
		wr(6'h02, 32'h0);
		wr(6'h03, 32'h2);
		tick(2);
		chk(pci_local_irq_pin, 8'h00);
	endtask
	// PCI soft trigger on every line
	task testPciSoft();
		for (int l = 0; l < 8; l++) begin
			wr(6'h05, l);
			wr(6'h02, 32'h1);
			tick(2);
			chk(pci_local_irq_pin, 8'h01 << l);
			chk(vme_irq_out_level, 7'h00);
			rdc(6'h03, 32'h1);
			wr(6'h02, 32'h0);
		end
	endtask
	// Bus error during acknowledge with a failed status/ID fetch
	task testFetchErr();
		wr(6'h04, 32'h20);
		wr(6'h05, 32'h600); // Bus error to PCI line 6
		wr(6'h02, 32'hC);
		wr(6'h06, 32'h50); // Bus error also to level 5
		wr(6'h00, 32'h200);
		far.busErr({32'h12345678, 6'h2D, 1'b0, 1'b1});
		far.done({3'd2, 8'h5A, 1'b1});
		tick(2);
		rdc(6'h07, 32'h6D);
		rdc(6'h08, 32'h12345678);
		rdc(6'h0B, 32'h15A); // Flag marks the id unusable
		rdc(6'h01, 32'h204);
		chk(pci_local_irq_pin, 8'h50);
		chk(vme_irq_out_level, 7'h10);
		far.ack(3'd5);
		tick(0);
		chk(statIdOut, 8'hA5);
		tick(2);
		chk(vme_irq_out_level, 7'h10);
		wr(6'h01, 32'h0);
		rdc(6'h01, 32'h204);
		wr(6'h01, 32'h204);
		rdc(6'h01, 32'h0);
		chk(vme_irq_out_level, 7'h00);
		chk(pci_local_irq_pin, 8'h00);
	endtask
	// Counts and verdict
	task finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		testRegs();
		testLevels();
		testSingle();
		testPciSoft();
		testFetchErr();
		finish_test();
	end
	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#400000;
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
